// ### hw/fsq_top.sv
// Flash programming sequencer with AHB-Lite register slave.
// Assumes hready is this slave's own hreadyout and that the core
// status inputs and flash handshake run on clk_sys.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////
// Contract
// (R1) Firmware enables function before any operation
// (R2) Firmware loads address, data, command first
// (R3) Writing one to trigger bit zero starts
// (R4) Hold program counter until operation completes
// (R5) Trigger self-clears and always reads zero
// (R6) Enable bit runs timing oscillator
// (R7) Firmware disables function when finished
// (R8) Fault: application code modifies application area
// (R9) Fault: application modifies loader, update disabled
// (R10) Fault: application code touches setup bytes
// (R11) Fault: loader modifies itself, or oversize
// (R12) Fault: operation while running into external
// (R13) Fault flag cleared only by software
// (R14) Loader update bit gates application writes
// (R15) Command holds area, oe, ce, action
// (R16) Address high supplies target bits 15:8
// (R17) Address low supplies bits 7:0
// (R18) Data register: program source, read result
// (R19) Decode erase, program, read, standby codes
// (R20) Page erase ignores the low address byte
// (R21) Faulted operation aborts but still releases; a fault raised in ST_RUN lets the flash operation finish
// (R22) Enable polarity is a parameter
module fsq_top #(
  parameter logic        ENABLE_LEVEL = 1'b1,
  parameter logic [16:0] APP_SIZE     = 17'h10000,
  parameter logic [16:0] LDR_SIZE     = 17'h01000
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic                   exec_in_loader,
  input  wire logic                   exec_external,
  output logic                        cpu_hold,
  output logic                        rc_osc_enable,
  output fsq_pkg::fsq_flash_req_t     flash_req,
  output logic                        flash_valid,
  input  wire logic                   flash_done,
  input  wire logic [7:0]             flash_rdata
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  function automatic fsq_pkg::fsq_op_t cmd_op(
    input fsq_pkg::fsq_cmd_t c
  );
    fsq_pkg::fsq_op_t o;
    o = fsq_pkg::OP_NONE;
    if (!c.ce && c.oe && c.action == fsq_pkg::ACT_ERASE) begin
      o = fsq_pkg::OP_ERASE;
    end else if (!c.ce && c.oe && c.action == fsq_pkg::ACT_PROG) begin
      o = fsq_pkg::OP_PROG;
    end else if (!c.ce && !c.oe && c.action == fsq_pkg::ACT_READ) begin
      o = fsq_pkg::OP_READ;
    end
    return o;
  endfunction

  function automatic logic is_modify(
    input fsq_pkg::fsq_op_t o
  );
    return (o == fsq_pkg::OP_ERASE) || (o == fsq_pkg::OP_PROG);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers and state

  logic                    cc_fault_r;
  logic                    cc_ldu_r;
  logic                    cc_en_r;
  logic [7:0]              cmd_r;
  logic [7:0]              addr_hi_r;
  logic [7:0]              addr_lo_r;
  logic [7:0]              data_r;
  fsq_pkg::fsq_state_t     state_r;
  logic                    wr_pend_r;
  logic [7:0]              wr_idx_r;
  logic                    fault_nxt;
  logic                    func_on;
  logic                    addr_ok;
  logic                    rd_ok;
  logic [7:0]              acc_idx;
  logic [7:0]              rd_byte;
  logic [15:0]             tgt16;
  fsq_pkg::fsq_cmd_t       cmd_s;
  fsq_pkg::fsq_op_t        op_s;
  logic                    wr_cc;
  logic                    wr_tg;
  logic                    wr_cmd;
  logic                    wr_hi;
  logic                    wr_lo;
  logic                    wr_dat;
  logic                    go_accept;
  logic                    run_fault;

  assign cmd_s   = fsq_pkg::fsq_cmd_t'(cmd_r);
  assign op_s    = cmd_op(cmd_s);
  assign tgt16   = {addr_hi_r, addr_lo_r};
  assign func_on = (cc_en_r == ENABLE_LEVEL); // (R22)

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase

  assign acc_idx = haddr[fsq_pkg::IDX_MSB:fsq_pkg::IDX_LSB];
  assign addr_ok = hsel && hready && htrans[1]
                   && (haddr[31:10] == 22'h000000)
                   && (haddr[1:0] == 2'h0)
                   && (hsize == fsq_pkg::HSIZE_WORD);
  assign rd_ok   = addr_ok && !hwrite;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_idx_r  <= acc_idx;
    end
  end

  // Write strobes land in the data phase
  assign wr_cc  = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_CHIP_CTRL);
  assign wr_tg  = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_TRIGGER);
  assign wr_cmd = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_COMMAND);
  assign wr_hi  = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_ADDR_HIGH);
  assign wr_lo  = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_ADDR_LOW);
  assign wr_dat = wr_pend_r && (wr_idx_r == fsq_pkg::IDX_DATA);

  ////////////////////////////////////////////////////////////////////
  // Read data, registered into the data phase

  always_comb begin
    rd_byte = 8'h00;
    case (acc_idx)
      fsq_pkg::IDX_CHIP_CTRL: begin
        rd_byte[fsq_pkg::CC_FAULT_BIT] = cc_fault_r;
        rd_byte[fsq_pkg::CC_LDU_BIT]   = cc_ldu_r;
        rd_byte[fsq_pkg::CC_EN_BIT]    = cc_en_r;
      end
      fsq_pkg::IDX_TRIGGER: begin
        rd_byte = 8'h00; // (R5)
      end
      fsq_pkg::IDX_COMMAND: begin
        rd_byte = cmd_r;
      end
      fsq_pkg::IDX_ADDR_HIGH: begin
        rd_byte = addr_hi_r;
      end
      fsq_pkg::IDX_ADDR_LOW: begin
        rd_byte = addr_lo_r;
      end
      fsq_pkg::IDX_DATA: begin
        rd_byte = data_r;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= fsq_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= fsq_pkg::HRESP_OKAY;
      if (rd_ok) begin
        hrdata <= {24'h000000, rd_byte};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Chip control

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cc_ldu_r <= 1'b0;
      cc_en_r  <= ~ENABLE_LEVEL;
    end else if (wr_cc) begin
      cc_ldu_r <= hwdata[fsq_pkg::CC_LDU_BIT];
      cc_en_r  <= hwdata[fsq_pkg::CC_EN_BIT];
    end
  end

  // Hardware set beats a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cc_fault_r <= 1'b0;
    end else if (fault_nxt || run_fault) begin
      cc_fault_r <= 1'b1;
    end else if (wr_cc) begin
      cc_fault_r <= hwdata[fsq_pkg::CC_FAULT_BIT]; // (R13)
    end
  end

  // Timing oscillator follows the enable bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rc_osc_enable <= 1'b0;
    end else begin
      rc_osc_enable <= func_on; // (R6)
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command, address and data registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r     <= fsq_pkg::RST_COMMAND;
      addr_hi_r <= fsq_pkg::RST_ADDR_HIGH;
      addr_lo_r <= fsq_pkg::RST_ADDR_LOW;
    end else begin
      if (wr_cmd) begin
        cmd_r <= hwdata[7:0]; // (R15)
      end
      if (wr_hi) begin
        addr_hi_r <= hwdata[7:0]; // (R16)
      end
      if (wr_lo) begin
        addr_lo_r <= hwdata[7:0]; // (R17)
      end
    end
  end

  // Read result has priority over a software write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= fsq_pkg::RST_DATA;
    end else if (state_r == fsq_pkg::ST_RUN && flash_done
                 && flash_req.op == fsq_pkg::OP_READ) begin
      data_r <= flash_rdata; // (R18)
    end else if (wr_dat) begin
      data_r <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Access checks

  always_comb begin
    fault_nxt = 1'b0;
    if (state_r == fsq_pkg::ST_CHECK && op_s != fsq_pkg::OP_NONE) begin
      if (exec_external) begin
        fault_nxt = 1'b1; // (R12)
      end
      case (cmd_s.area)
        fsq_pkg::AREA_APP: begin
          if (!exec_in_loader && is_modify(op_s)) begin
            fault_nxt = 1'b1; // (R8)
          end
          if ({1'b0, tgt16} >= APP_SIZE) begin
            fault_nxt = 1'b1; // (R11)
          end
        end
        fsq_pkg::AREA_LDR: begin
          if (!exec_in_loader && is_modify(op_s) && !cc_ldu_r) begin
            fault_nxt = 1'b1; // (R9) (R14)
          end
          if (exec_in_loader && is_modify(op_s)) begin
            fault_nxt = 1'b1; // (R11)
          end
          if ({1'b0, tgt16} >= LDR_SIZE) begin
            fault_nxt = 1'b1; // (R11)
          end
        end
        fsq_pkg::AREA_CFG: begin
          if (!exec_in_loader) begin
            fault_nxt = 1'b1; // (R10)
          end
          if (op_s == fsq_pkg::OP_ERASE) begin
            if (addr_hi_r != 8'h00) begin
              fault_nxt = 1'b1; // (R11)
            end
          end else if (tgt16 > fsq_pkg::CFG_LAST_ADDR) begin
            fault_nxt = 1'b1; // (R11)
          end
        end
        default: begin
          fault_nxt = 1'b1; // (R11)
        end
      endcase
    end
  end

  assign run_fault = (state_r == fsq_pkg::ST_RUN) && exec_external; // (R12)

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  assign go_accept = wr_tg && hwdata[fsq_pkg::TRIG_GO_BIT]
                     && func_on && (state_r == fsq_pkg::ST_IDLE); // (R3)

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= fsq_pkg::ST_IDLE;
    end else begin
      case (state_r)
        fsq_pkg::ST_IDLE: begin
          if (go_accept) begin
            state_r <= fsq_pkg::ST_CHECK;
          end
        end
        fsq_pkg::ST_CHECK: begin
          if (fault_nxt || op_s == fsq_pkg::OP_NONE) begin
            state_r <= fsq_pkg::ST_DONE; // (R21) (R19)
          end else begin
            state_r <= fsq_pkg::ST_RUN;
          end
        end
        fsq_pkg::ST_RUN: begin
          if (flash_done) begin
            state_r <= fsq_pkg::ST_DONE;
          end
        end
        fsq_pkg::ST_DONE: begin
          state_r <= fsq_pkg::ST_IDLE; // (R5)
        end
        default: begin
          state_r <= fsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Core stalls from trigger until the sequence retires
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_hold <= 1'b0;
    end else if (go_accept) begin
      cpu_hold <= 1'b1; // (R4)
    end else if (state_r == fsq_pkg::ST_DONE) begin
      cpu_hold <= 1'b0; // (R4) (R21)
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flash request

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_valid <= 1'b0;
      flash_req   <= '0;
    end else if (state_r == fsq_pkg::ST_CHECK
                 && !fault_nxt && op_s != fsq_pkg::OP_NONE) begin
      flash_valid        <= 1'b1;
      flash_req.op       <= op_s; // (R19)
      flash_req.wdata    <= data_r; // (R18)
      flash_req.addr     <= {cmd_s.area, tgt16};
      if (op_s == fsq_pkg::OP_ERASE) begin
        flash_req.addr[7:0] <= 8'h00; // (R20)
      end
    end else if (state_r == fsq_pkg::ST_RUN && flash_done) begin
      flash_valid <= 1'b0;
    end
  end

endmodule

// ### pkg/fsq_pkg.sv
// Shared constants and types of the flash programming sequencer.
// Assumes one AHB-Lite master and a flash macro with a req/done handshake.
package fsq_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CHIP_CTRL = 8'h9f;
  localparam logic [7:0] IDX_TRIGGER   = 8'ha4;
  localparam logic [7:0] IDX_COMMAND   = 8'ha5;
  localparam logic [7:0] IDX_ADDR_LOW  = 8'ha6;
  localparam logic [7:0] IDX_ADDR_HIGH = 8'ha7;
  localparam logic [7:0] IDX_DATA      = 8'hae;

  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // Field positions
  localparam int unsigned CC_FAULT_BIT = 6;
  localparam int unsigned CC_LDU_BIT   = 5;
  localparam int unsigned CC_EN_BIT    = 0;
  localparam int unsigned TRIG_GO_BIT  = 0;

  // Values after reset
  localparam logic [7:0] RST_ADDR_LOW  = 8'h00;
  localparam logic [7:0] RST_ADDR_HIGH = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_COMMAND   = 8'h30;

  // Command encodings
  localparam logic [3:0] ACT_READ  = 4'h0;
  localparam logic [3:0] ACT_PROG  = 4'h1;
  localparam logic [3:0] ACT_ERASE = 4'h2;
  localparam logic [1:0] AREA_APP  = 2'h0;
  localparam logic [1:0] AREA_LDR  = 2'h1;
  localparam logic [1:0] AREA_CFG  = 2'h3;
  localparam logic [15:0] CFG_LAST_ADDR = 16'h0003;

  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_PROG  = 2'b10,
    OP_ERASE = 2'b11
  } fsq_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN   = 2'b10,
    ST_DONE  = 2'b11
  } fsq_state_t;

  typedef struct packed {
    logic [1:0] area;
    logic       oe;
    logic       ce;
    logic [3:0] action;
  } fsq_cmd_t;

  typedef struct packed {
    fsq_op_t     op;
    logic [17:0] addr;
    logic [7:0]  wdata;
  } fsq_flash_req_t;

endpackage

// ### dv/fsq_props.sv
// Assertion checker for the flash programming sequencer.
// Bound to fsq_top; sees its ports only.
`timescale 1ns/1ps
module fsq_props #(
  parameter logic ENABLE_LEVEL = 1'b1
) (
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic [31:0]             hrdata,
  input wire logic                    hresp,
  input wire logic                    exec_in_loader,
  input wire logic                    exec_external,
  input wire logic                    cpu_hold,
  input wire logic                    rc_osc_enable,
  input wire fsq_pkg::fsq_flash_req_t flash_req,
  input wire logic                    flash_valid,
  input wire logic                    flash_done,
  input wire logic [7:0]              flash_rdata
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic taken;
  logic rd_trig_r;
  logic wr_cc_r;
  logic en_want_r;
  assign taken = hsel && hready && htrans[1] && hsize == fsq_pkg::HSIZE_WORD;
  ////////////////////////////////////////////////////////////////
  // Track data phases of trigger reads and control writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_trig_r <= 1'b0;
      wr_cc_r   <= 1'b0;
      en_want_r <= ~ENABLE_LEVEL;
    end else begin
      rd_trig_r <= taken && !hwrite && haddr == 32'h0000_0290;
      wr_cc_r   <= taken && hwrite && haddr == 32'h0000_027c;
      if (wr_cc_r) begin
        en_want_r <= hwdata[fsq_pkg::CC_EN_BIT];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  a_trig_reads_zero: assert property (rd_trig_r |-> hrdata == 32'h0)
    else $error("trigger read back nonzero");
  a_hold_min_span: assert property ($rose(cpu_hold) |-> cpu_hold [*2])
    else $error("hold released too early");
  a_valid_in_hold: assert property (flash_valid |-> cpu_hold)
    else $error("flash request without hold");
  a_valid_until_done: assert property (flash_valid && !flash_done |=> flash_valid)
    else $error("flash request dropped before done");
  a_done_releases: assert property (flash_valid && flash_done |=> !flash_valid ##1 !cpu_hold)
    else $error("done did not release hold");
  a_req_stable: assert property (flash_valid && $past(flash_valid) |-> $stable(flash_req))
    else $error("flash request changed while valid");
  a_erase_page: assert property (flash_valid && flash_req.op == fsq_pkg::OP_ERASE |->
    flash_req.addr[7:0] == 8'h00)
    else $error("erase address low byte not zero");
  a_ext_aborts: assert property ($rose(cpu_hold) && exec_external |=> !flash_valid)
    else $error("operation launched during external run");
  a_osc_follows: assert property (wr_cc_r |-> ##2 rc_osc_enable == (en_want_r == ENABLE_LEVEL))
    else $error("oscillator enable does not follow enable bit");
endmodule

bind fsq_top fsq_props #(.ENABLE_LEVEL(ENABLE_LEVEL)) u_props (.clk_sys, .rst_n, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
  .exec_in_loader, .exec_external, .cpu_hold, .rc_osc_enable, .flash_req, .flash_valid,
  .flash_done, .flash_rdata);

// ### dv/fsq_flash_model.sv
// Behavioural flash macro answering the sequencer request handshake.
// Latency comes from the bench; erased bytes read 8'hff.
`timescale 1ns/1ps
module fsq_flash_model (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire fsq_pkg::fsq_flash_req_t flash_req,
  input  wire logic                    flash_valid,
  input  wire logic [7:0]              lat,
  output logic                         flash_done,
  output logic [7:0]                   flash_rdata
);
  logic [7:0] mem [logic [17:0]];
  logic [7:0] cnt_r;
  logic       used_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_done  <= 1'b0;
      flash_rdata <= 8'h5a;
      cnt_r       <= 8'h0;
      used_r      <= 1'b0;
    end else begin
      flash_done  <= 1'b0;
      flash_rdata <= ~flash_rdata;
      cnt_r       <= cnt_r + 8'h1;
      if (!flash_valid || used_r) begin
        cnt_r  <= 8'h0;
        used_r <= flash_valid;
      end else if (cnt_r >= lat) begin
        flash_done <= 1'b1;
        used_r     <= 1'b1;
        case (flash_req.op)
          fsq_pkg::OP_READ: flash_rdata <= mem.exists(flash_req.addr) ?
            mem[flash_req.addr] : 8'hff;
          fsq_pkg::OP_PROG: mem[flash_req.addr] = flash_req.wdata;
          fsq_pkg::OP_ERASE: for (int i = 0; i < 256; i++) begin
            mem.delete({flash_req.addr[17:8], 8'(i)});
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// ### dv/tb_fsq_top.sv
// Self-checking bench for the flash programming sequencer.
// Drives AHB-Lite and core status; a flash model answers.
`timescale 1ns/1ps
module tb_fsq_top;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [2:0]              hsize = 3'h2;
  logic [31:0]             hwdata = 32'h0;
  logic                    ldr = 1'b0;
  logic                    ext = 1'b0;
  logic [7:0]              lat = 8'h0;
  logic                    hreadyout, hresp, cpu_hold, rc_osc_enable, flash_valid, flash_done;
  logic [31:0]             hrdata;
  logic [7:0]              flash_rdata, rd;
  fsq_pkg::fsq_flash_req_t flash_req;
  logic [7:0]              shadow [logic [17:0]];
  int                      num_errors = 0;
  int                      n_tests = 0;
  int                      seed;

  always #4 clk_sys = ~clk_sys;

  fsq_top dut_u (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .exec_in_loader(ldr),
    .exec_external(ext), .cpu_hold, .rc_osc_enable, .flash_req, .flash_valid,
    .flash_done, .flash_rdata);
  fsq_flash_model flash_u (.clk_sys, .rst_n, .flash_req, .flash_valid, .lat,
    .flash_done, .flash_rdata);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: expected %h got %h", $time, exp, got);
      num_errors++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int t = 0;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    // Address phase ends at the rising edge that samples hready high
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++t < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    // Data phase ends likewise; read data and response taken there
    do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++t < 64);
    rd = hrdata[7:0];
    chk(32'h0, {31'h0, hresp});
    if (t >= 64) num_errors++;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h0);
    chk({24'h0, exp}, {24'h0, rd});
  endtask

  function automatic logic flt(logic l, logic u, logic [1:0] a, logic [3:0] act, logic x,
                               logic [7:0] hi);
    logic m;
    m = act != fsq_pkg::ACT_READ;
    if (x) return 1'b1;
    case (a)
      fsq_pkg::AREA_APP: return !l && m;
      fsq_pkg::AREA_LDR: return hi >= 8'h10 || (m && (l || !u));
      fsq_pkg::AREA_CFG: return !l || hi != 8'h0;
      default: return 1'b1;
    endcase
  endfunction

  task automatic op(logic [1:0] a, logic [3:0] act, logic [7:0] hi, logic [7:0] lo,
                    logic [7:0] d, logic u, logic pf);
    logic        nf;
    logic [17:0] k;
    logic [7:0]  c;
    int          t = 0;
    nf = flt(ldr, u, a, act, ext, hi);
    k = {a, hi, lo};
    c = {a, act != fsq_pkg::ACT_READ, 1'b0, act};
    wr(8'ha5, c);
    wr(8'ha7, hi);
    wr(8'ha6, lo);
    wr(8'hae, d);
    rdc(8'ha5, c);
    lat <= 8'($urandom_range(0, 12));
    wr(8'ha4, 8'h01);
    @(negedge clk_sys);
    chk(32'h1, {31'h0, cpu_hold});
    do @(negedge clk_sys); while (cpu_hold !== 1'b0 && ++t < 200);
    chk(32'h0, {31'h0, cpu_hold});
    rdc(8'h9f, {1'b0, pf | nf, u, 5'h01});
    rdc(8'ha4, 8'h00);
    rdc(8'hae, (act == fsq_pkg::ACT_READ && !nf) ?
      (shadow.exists(k) ? shadow[k] : 8'hff) : d);
    if (!nf && act == fsq_pkg::ACT_PROG) shadow[k] = d;
    if (!nf && act == fsq_pkg::ACT_ERASE) begin
      for (int i = 0; i < 256; i++) shadow.delete({a, hi, 8'(i)});
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 60000);
    num_errors++;
    end_sim();
  end

  initial begin
    logic [7:0] ix [7];
    logic [7:0] rv [7];
    logic [7:0] hs [4];
    logic [7:0] d;
    logic       u;
    ix = '{8'h9f, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hae, 8'ha8};
    rv = '{8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00};
    hs = '{8'h00, 8'h01, 8'h0f, 8'h10};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    seed = $urandom(32'h3d4b0367);
    for (int i = 0; i < 7; i++) rdc(ix[i], rv[i]);
    for (int i = 2; i < 6; i++) begin
      d = 8'($urandom);
      wr(ix[i], d);
      rdc(ix[i], d);
    end
    wr(8'ha6, 8'h5a);
    hsize <= 3'h0;
    wr(8'ha6, 8'ha5);
    hsize <= 3'h2;
    rdc(8'ha6, 8'h5a);
    wr(8'ha8, 8'hff);
    rdc(8'ha8, 8'h00);
    wr(8'ha4, 8'h01);
    @(negedge clk_sys);
    chk(32'h0, {31'h0, cpu_hold});
    chk(32'h0, {31'h0, rc_osc_enable});
    wr(8'h9f, 8'hff);
    rdc(8'h9f, 8'h61);
    chk(32'h1, {31'h0, rc_osc_enable});
    repeat (120) begin
      u = 1'($urandom);
      ldr <= 1'($urandom);
      ext <= $urandom_range(0, 7) == 0;
      wr(8'h9f, {2'b00, u, 5'h01});
      op(2'($urandom), 4'($urandom_range(0, 2)), hs[$urandom_range(0, 3)],
         8'($urandom_range(0, 3)), 8'($urandom), u, 1'b0);
    end
    ldr <= 1'b0;
    ext <= 1'b0;
    wr(8'h9f, 8'h01);
    op(fsq_pkg::AREA_APP, fsq_pkg::ACT_PROG, 8'h00, 8'h00, 8'h3c, 1'b0, 1'b0);
    op(fsq_pkg::AREA_LDR, fsq_pkg::ACT_READ, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    wr(8'h9f, 8'h01);
    wr(8'ha5, 8'h30);
    wr(8'ha4, 8'h01);
    repeat (8) @(posedge clk_sys);
    rdc(8'h9f, 8'h01);
    wr(8'h9f, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk(32'h0, {31'h0, rc_osc_enable});
    end_sim();
  end
endmodule
